// ==== hdl/spi_link_pkg.sv ====
// Shared constants and state types for the SPI sensor link
package spi_link_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int RW_BIT = 7;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;
  localparam logic ADDR_TOP = 1'h1;
  localparam int RD_LEN_W = 8;
  localparam int FRAME_BITS_W = 12;
  localparam int WR_PAIR_BITS = 16;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GUARD_NS = 20;
  localparam int CS_GUARD_CYC = (CS_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  typedef enum logic [2:0]
  {
    DEV_CTRL  = 3'h1,
    DEV_WDATA = 3'h2,
    DEV_RDATA = 3'h4
  } dev_state_t;

  typedef enum logic [4:0]
  {
    H_IDLE  = 5'h01,
    H_SETUP = 5'h02,
    H_SHIFT = 5'h04,
    H_GAP   = 5'h08,
    H_END   = 5'h10
  } host_state_t;
endpackage

// ==== hdl/spi_link_if.sv ====
// Serial link wiring between the master end and the sensor port end
`timescale 1ns/1ps
interface spi_link_if;
  logic sck;
  logic csb_n;
  logic sdi_m_o;
  logic sdi_m_oe_n;
  logic sdi_s_o;
  logic sdi_s_oe_n;
  logic sdo_o;
  logic sdo_oe_n;
  logic sdi_line;
  logic sdo_line;

  // Undriven lines read high, standing in for a weak pull-up
  assign sdi_line = !sdi_m_oe_n ? sdi_m_o : (!sdi_s_oe_n ? sdi_s_o : 1'h1);
  assign sdo_line = !sdo_oe_n ? sdo_o : 1'h1;

  modport dev
  (
    input  sck,
    input  csb_n,
    input  sdi_line,
    output sdi_s_o,
    output sdi_s_oe_n,
    output sdo_o,
    output sdo_oe_n
  );

  modport host
  (
    output sck,
    output csb_n,
    output sdi_m_o,
    output sdi_m_oe_n,
    input  sdi_line,
    input  sdo_line
  );
endinterface

// ==== hdl/spi_sensor_port.sv ====
// Sensor-side SPI slave port: frame logic on the serial clock, register handoff on clk
`timescale 1ns/1ps
module spi_sensor_port
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  spi_link_if.dev                         link,
  input  wire logic                       three_wire_enable,
  output logic                            reg_wr,
  output logic [spi_link_pkg::BYTE_W-1:0] reg_wr_addr,
  output logic [spi_link_pkg::BYTE_W-1:0] reg_wr_data,
  output logic                            reg_rd,
  output logic [spi_link_pkg::BYTE_W-1:0] reg_rd_addr,
  input  wire logic [spi_link_pkg::BYTE_W-1:0] reg_rd_data,
  output logic                            mode11,
  output logic                            two_wire_disable
);
  import spi_link_pkg::*;

  dev_state_t              state_q;
  logic [2:0]              bit_q;
  logic [ADDR_W-1:0]       shift_q;
  logic [ADDR_W-1:0]       addr_q;
  logic                    load_q;
  logic                    tw_s1_q;
  logic                    tw_q;
  logic                    rd_tog_q;
  logic [ADDR_W-1:0]       rd_req_addr_q;
  logic                    wr_tog_q;
  logic [ADDR_W-1:0]       wr_req_addr_q;
  logic [BYTE_W-1:0]       wr_req_data_q;
  logic [BYTE_W-1:0]       out_q;
  logic                    sdo_oe_n_q;
  logic                    sdi_oe_n_q;
  logic                    mode_cap_q;
  logic                    rd_s1_q;
  logic                    rd_s2_q;
  logic                    rd_s3_q;
  logic                    wr_s1_q;
  logic                    wr_s2_q;
  logic                    wr_s3_q;
  logic                    mode_s1_q;
  logic                    mode_s2_q;
  logic                    cs_s1_q;
  logic                    cs_s2_q;
  logic                    reg_rd_q;
  logic [BYTE_W-1:0]       reg_rd_addr_q;
  logic [BYTE_W-1:0]       hold_q;
  logic                    reg_wr_q;
  logic [BYTE_W-1:0]       reg_wr_addr_q;
  logic [BYTE_W-1:0]       reg_wr_data_q;
  logic                    two_wire_disable_q;
  logic [BYTE_W-1:0]       rx_byte;
  logic                    byte_end;

  assign rx_byte = {shift_q, link.sdi_line};
  assign byte_end = (bit_q == 3'h7);

  // Mode is the clock level seen as select falls; the master holds it still there
  always_ff @(negedge link.csb_n or posedge reset)
  begin
    if (reset)
      mode_cap_q <= 1'h0;
    else
      mode_cap_q <= link.sck;
  end

  // Config level into the serial clock domain
  always_ff @(posedge link.sck or posedge reset)
  begin
    if (reset)
    begin
      tw_s1_q <= 1'h0;
      tw_q    <= 1'h0;
    end
    else
    begin
      tw_s1_q <= three_wire_enable;
      tw_q    <= tw_s1_q;
    end
  end

  // Frame decoder; select high clears it asynchronously, so a cut byte is lost
  always_ff @(posedge link.sck or posedge link.csb_n)
  begin
    if (link.csb_n)
    begin
      state_q <= DEV_CTRL;
      bit_q   <= 3'h0;
      shift_q <= '0;
      addr_q  <= '0;
      load_q  <= 1'h0;
    end
    else
    begin
      bit_q   <= bit_q + 3'h1;
      shift_q <= rx_byte[ADDR_W-1:0];
      load_q  <= 1'h0;
      if (byte_end)
      begin
        unique case (state_q)
          DEV_CTRL:
          begin
            addr_q  <= rx_byte[ADDR_W-1:0];
            load_q  <= (rx_byte[RW_BIT] == RW_READ);
            state_q <= (rx_byte[RW_BIT] == RW_READ) ? DEV_RDATA : DEV_WDATA;
          end
          DEV_WDATA:
            state_q <= DEV_CTRL;
          DEV_RDATA:
          begin
            addr_q <= addr_q + 7'h01;
            load_q <= 1'h1;
          end
          default:
            state_q <= DEV_CTRL;
        endcase
      end
    end
  end

  // Requests toward clk keep their value across frames, so no false toggle at select
  always_ff @(posedge link.sck or posedge reset)
  begin
    if (reset)
    begin
      rd_tog_q      <= 1'h0;
      rd_req_addr_q <= '0;
      wr_tog_q      <= 1'h0;
      wr_req_addr_q <= '0;
      wr_req_data_q <= BYTE_RST;
    end
    else if (byte_end)
    begin
      if (state_q == DEV_CTRL && rx_byte[RW_BIT] == RW_READ)
      begin
        rd_tog_q      <= ~rd_tog_q;
        rd_req_addr_q <= rx_byte[ADDR_W-1:0];
      end
      if (state_q == DEV_RDATA)
      begin
        rd_tog_q      <= ~rd_tog_q;
        rd_req_addr_q <= addr_q + 7'h01;
      end
      if (state_q == DEV_WDATA)
      begin
        wr_tog_q      <= ~wr_tog_q;
        wr_req_addr_q <= addr_q;
        wr_req_data_q <= rx_byte;
      end
    end
  end

  // Output shifter; hold_q settles well inside half a clock, so it is read directly
  always_ff @(negedge link.sck or posedge link.csb_n)
  begin
    if (link.csb_n)
    begin
      out_q      <= BYTE_RST;
      sdo_oe_n_q <= 1'h1;
      sdi_oe_n_q <= 1'h1;
    end
    else if (load_q)
    begin
      out_q      <= hold_q;
      sdo_oe_n_q <= tw_q;
      sdi_oe_n_q <= ~tw_q;
    end
    else
    begin
      out_q <= {out_q[BYTE_W-2:0], 1'h0};
    end
  end

  assign link.sdo_o      = out_q[BYTE_W-1];
  assign link.sdi_s_o    = out_q[BYTE_W-1];
  assign link.sdo_oe_n   = sdo_oe_n_q;
  assign link.sdi_s_oe_n = sdi_oe_n_q;

  // Toggle and level synchronisers into clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_s1_q   <= 1'h0;
      rd_s2_q   <= 1'h0;
      rd_s3_q   <= 1'h0;
      wr_s1_q   <= 1'h0;
      wr_s2_q   <= 1'h0;
      wr_s3_q   <= 1'h0;
      mode_s1_q <= 1'h0;
      mode_s2_q <= 1'h0;
      cs_s1_q   <= 1'h1;
      cs_s2_q   <= 1'h1;
    end
    else
    begin
      rd_s1_q   <= rd_tog_q;
      rd_s2_q   <= rd_s1_q;
      rd_s3_q   <= rd_s2_q;
      wr_s1_q   <= wr_tog_q;
      wr_s2_q   <= wr_s1_q;
      wr_s3_q   <= wr_s2_q;
      mode_s1_q <= mode_cap_q;
      mode_s2_q <= mode_s1_q;
      cs_s1_q   <= link.csb_n;
      cs_s2_q   <= cs_s1_q;
    end
  end

  // Read fetch: address out one cycle, data taken at the end of that cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rd_q      <= 1'h0;
      reg_rd_addr_q <= BYTE_RST;
      hold_q        <= BYTE_RST;
    end
    else
    begin
      reg_rd_q <= rd_s2_q ^ rd_s3_q;
      if (rd_s2_q ^ rd_s3_q)
        reg_rd_addr_q <= {ADDR_TOP, rd_req_addr_q};
      if (reg_rd_q)
        hold_q <= reg_rd_data;
    end
  end

  // Write delivery, one pulse per received pair
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_wr_q      <= 1'h0;
      reg_wr_addr_q <= BYTE_RST;
      reg_wr_data_q <= BYTE_RST;
    end
    else
    begin
      reg_wr_q <= wr_s2_q ^ wr_s3_q;
      if (wr_s2_q ^ wr_s3_q)
      begin
        reg_wr_addr_q <= {ADDR_TOP, wr_req_addr_q};
        reg_wr_data_q <= wr_req_data_q;
      end
    end
  end

  // Sticky until reset; a select pulse shorter than one clk cycle may be missed
  always_ff @(posedge clk)
  begin
    if (reset)
      two_wire_disable_q <= 1'h0;
    else
      two_wire_disable_q <= two_wire_disable_q | ~cs_s2_q;
  end

  assign reg_wr           = reg_wr_q;
  assign reg_wr_addr      = reg_wr_addr_q;
  assign reg_wr_data      = reg_wr_data_q;
  assign reg_rd           = reg_rd_q;
  assign reg_rd_addr      = reg_rd_addr_q;
  assign mode11           = mode_s2_q;
  assign two_wire_disable = two_wire_disable_q;
endmodule

// ==== hdl/spi_master_end.sv ====
// SPI master end: frames commands onto the link with a divided serial clock
`timescale 1ns/1ps
module spi_master_end
#(
  parameter int   HALF_CYC  = spi_link_pkg::SCK_HALF_CYC,
  parameter int   GUARD_CYC = spi_link_pkg::CS_GUARD_CYC,
  parameter logic MODE11    = 1'h1
)
(
  input  wire logic                         clk,
  input  wire logic                         reset,
  spi_link_if.host                          link,
  input  wire logic                         three_wire_enable,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire logic                         cmd_write,
  input  wire logic                         cmd_hold,
  input  wire logic [spi_link_pkg::BYTE_W-1:0]   cmd_addr,
  input  wire logic [spi_link_pkg::BYTE_W-1:0]   cmd_data,
  input  wire logic [spi_link_pkg::RD_LEN_W-1:0] cmd_len,
  output logic                              rsp_valid,
  output logic [spi_link_pkg::BYTE_W-1:0]   rsp_data,
  output logic                              busy
);
  import spi_link_pkg::*;

  host_state_t             state_q;
  logic [TIMER_W-1:0]      cnt_q;
  logic [FRAME_BITS_W-1:0] bits_q;
  logic [3:0]              ctl_q;
  logic [WR_PAIR_BITS-1:0] tx_q;
  logic                    is_read_q;
  logic                    hold_q;
  logic                    phase_q;
  logic                    sck_q;
  logic                    csb_n_q;
  logic                    mosi_q;
  logic                    mosi_oe_n_q;
  logic                    ready_q;
  logic                    busy_q;
  logic [BYTE_W-1:0]       rx_q;
  logic [2:0]              rxn_q;
  logic                    rsp_valid_q;
  logic [BYTE_W-1:0]       rsp_data_q;
  logic                    sdi_s1_q;
  logic                    sdi_s2_q;
  logic                    sdo_s1_q;
  logic                    sdo_s2_q;
  logic                    tick;
  logic                    acc;
  logic                    miso;
  logic                    sample;

  assign tick   = (cnt_q == '0);
  assign acc    = cmd_valid && ready_q && (state_q != H_GAP || cmd_write);
  assign miso   = three_wire_enable ? sdi_s2_q : sdo_s2_q;
  assign sample = (state_q == H_SHIFT) && tick && phase_q && (ctl_q == 4'h0);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sdi_s1_q <= 1'h1;
      sdi_s2_q <= 1'h1;
      sdo_s1_q <= 1'h1;
      sdo_s2_q <= 1'h1;
    end
    else
    begin
      sdi_s1_q <= link.sdi_line;
      sdi_s2_q <= sdi_s1_q;
      sdo_s1_q <= link.sdo_line;
      sdo_s2_q <= sdo_s1_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q     <= H_IDLE;
      cnt_q       <= '0;
      bits_q      <= '0;
      ctl_q       <= 4'h0;
      tx_q        <= '0;
      is_read_q   <= 1'h0;
      hold_q      <= 1'h0;
      phase_q     <= 1'h0;
      sck_q       <= MODE11;
      csb_n_q     <= 1'h1;
      mosi_q      <= 1'h0;
      mosi_oe_n_q <= 1'h1;
    end
    else
    begin
      if (!tick)
        cnt_q <= cnt_q - 16'h0001;
      unique case (state_q)
        H_IDLE, H_GAP:
        begin
          if (acc)
          begin
            tx_q      <= {cmd_write ? RW_WRITE : RW_READ, cmd_addr[ADDR_W-1:0], cmd_data};
            is_read_q <= !cmd_write;
            hold_q    <= cmd_hold;
            ctl_q     <= 4'h8;
            bits_q    <= cmd_write ? FRAME_BITS_W'(WR_PAIR_BITS)
                                   : FRAME_BITS_W'(BYTE_W) + {1'h0, cmd_len, 3'h0};
            csb_n_q   <= 1'h0;
            cnt_q     <= TIMER_W'(GUARD_CYC - 1);
            state_q   <= H_SETUP;
          end
          else if (state_q == H_GAP && cmd_valid && !cmd_write)
          begin
            cnt_q   <= TIMER_W'(GUARD_CYC - 1);
            state_q <= H_END;
          end
        end
        H_SETUP:
        begin
          if (tick)
          begin
            sck_q       <= 1'h0;
            mosi_q      <= tx_q[WR_PAIR_BITS-1];
            mosi_oe_n_q <= 1'h0;
            phase_q     <= 1'h0;
            cnt_q       <= TIMER_W'(HALF_CYC - 1);
            state_q     <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          if (tick)
          begin
            cnt_q <= TIMER_W'(HALF_CYC - 1);
            if (!phase_q)
            begin
              sck_q   <= 1'h1;
              phase_q <= 1'h1;
            end
            else
            begin
              tx_q   <= {tx_q[WR_PAIR_BITS-2:0], 1'h0};
              bits_q <= bits_q - 12'h001;
              if (ctl_q != 4'h0)
                ctl_q <= ctl_q - 4'h1;
              if (ctl_q == 4'h1 && is_read_q && three_wire_enable)
                mosi_oe_n_q <= 1'h1;
              if (bits_q == 12'h001)
              begin
                sck_q   <= MODE11;
                cnt_q   <= TIMER_W'(GUARD_CYC - 1);
                state_q <= (hold_q && !is_read_q) ? H_GAP : H_END;
              end
              else
              begin
                sck_q   <= 1'h0;
                mosi_q  <= tx_q[WR_PAIR_BITS-2];
                phase_q <= 1'h0;
              end
            end
          end
        end
        H_END:
        begin
          if (tick)
          begin
            csb_n_q     <= 1'h1;
            mosi_oe_n_q <= 1'h1;
            cnt_q       <= TIMER_W'(GUARD_CYC - 1);
            state_q     <= H_IDLE;
          end
        end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  // Ready is registered, so it lags a free slot by one cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ready_q <= 1'h0;
      busy_q  <= 1'h0;
    end
    else
    begin
      ready_q <= ((state_q == H_IDLE && tick) || state_q == H_GAP) && !acc;
      busy_q  <= (state_q != H_IDLE) || acc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_q        <= BYTE_RST;
      rxn_q       <= 3'h0;
      rsp_valid_q <= 1'h0;
      rsp_data_q  <= BYTE_RST;
    end
    else
    begin
      rsp_valid_q <= 1'h0;
      if (state_q == H_SETUP)
        rxn_q <= 3'h0;
      if (sample && is_read_q)
      begin
        rx_q  <= {rx_q[BYTE_W-2:0], miso};
        rxn_q <= rxn_q + 3'h1;
        if (rxn_q == 3'h7)
        begin
          rsp_valid_q <= 1'h1;
          rsp_data_q  <= {rx_q[BYTE_W-2:0], miso};
        end
      end
    end
  end

  assign link.sck        = sck_q;
  assign link.csb_n      = csb_n_q;
  assign link.sdi_m_o    = mosi_q;
  assign link.sdi_m_oe_n = mosi_oe_n_q;
  assign cmd_ready       = ready_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_data        = rsp_data_q;
  assign busy            = busy_q;
endmodule

// ==== testbench/spi_link_props.sv ====
// Concurrent checks on the serial link between the master end and the sensor port
`timescale 1ns/1ps
module spi_link_props
(
  input wire logic clk,
  input wire logic reset,
  input wire logic three_wire_enable,
  input wire logic sck,
  input wire logic csb_n,
  input wire logic sdi_m_o,
  input wire logic sdi_m_oe_n,
  input wire logic sdi_s_o,
  input wire logic sdi_s_oe_n,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  input wire logic mode11,
  input wire logic two_wire_disable
);
  logic [11:0] rise_q;

  default clocking
    @(posedge clk);
  endclocking
  default disable iff (reset);

  // Oversampled on clk; safe because a serial clock half period spans several clk cycles
  always_ff @(posedge clk)
    if (reset || csb_n)
      rise_q <= 12'h000;
    else if ($rose(sck))
      rise_q <= rise_q + 12'h001;

  property p_sdo_3w;
    three_wire_enable |-> sdo_oe_n;
  endproperty
  a_sdo_3w: assert property (p_sdo_3w)
    else $error("dedicated output driven in three-wire mode");
  property p_sdi_4w;
    !three_wire_enable |-> sdi_s_oe_n;
  endproperty
  a_sdi_4w: assert property (p_sdi_4w)
    else $error("shared pin driven in four-wire mode");
  property p_release;
    csb_n [*2] |-> sdo_oe_n && sdi_s_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data pin still driven after select rose");
  property p_sck_still;
    $changed(csb_n) |-> $stable(sck);
  endproperty
  a_sck_still: assert property (p_sck_still)
    else $error("serial clock moved at a select edge");
  property p_mode;
    $fell(csb_n) && sck |-> ##[1:8] mode11;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode 11 not detected");
  property p_lock_rise;
    $fell(csb_n) |-> ##[0:4] two_wire_disable;
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("two-wire port not disabled");
  property p_lock_hold;
    two_wire_disable |=> two_wire_disable;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("two-wire disable dropped");
  property p_dev_edge;
    (!sdo_oe_n && $changed(sdo_o)) || (!sdi_s_oe_n && $changed(sdi_s_o)) |-> !sck;
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device output changed outside clock low phase");
  property p_host_edge;
    !sdi_m_oe_n && $changed(sdi_m_o) |-> !sck;
  endproperty
  a_host_edge: assert property (p_host_edge)
    else $error("master data changed outside clock low phase");
  property p_byte_len;
    $rose(csb_n) |-> rise_q[2:0] == 3'h0;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("frame not a whole number of bytes");

  c_frame: cover property ($fell(csb_n));
  c_rd_4w: cover property (!sdo_oe_n);
  c_rd_3w: cover property (!sdi_s_oe_n && three_wire_enable);
endmodule

// ==== testbench/test_sensor_spi_slave_port.sv ====
// Self-checking bench joining a mode 11 and a mode 00 master end to sensor ports, each pair over its own link
`timescale 1ns/1ps
module test_sensor_spi_slave_port;
  import spi_link_pkg::*;
  localparam logic [7:0] WA [2][3] = '{'{8'h00, 8'h7F, 8'h34}, '{8'h35, 8'h7F, 8'h35}};
  localparam logic [7:0] WD [2][3] = '{'{8'hA5, 8'h5A, 8'hC3}, '{8'h96, 8'h0F, 8'h69}};
  localparam logic [7:0] RA [2]    = '{8'h7F, 8'h34};
  localparam logic [7:0] ER [2][3] = '{'{8'h5A, 8'hA5, 8'hBD}, '{8'hC3, 8'h69, 8'h8A}};
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        three_wire_enable = 1'h0;
  logic        cmd_valid = 1'h0;
  logic        cmd_write = 1'h0;
  logic        cmd_hold = 1'h0;
  logic [7:0]  cmd_addr = 8'h00;
  logic [7:0]  cmd_data = 8'h00;
  logic [7:0]  cmd_len = 8'h00;
  logic        cmd_ready, rsp_valid, busy, reg_wr, reg_rd, mode11, two_wire_disable;
  logic [7:0]  rsp_data, reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  logic [7:0]  mem [256];
  logic [15:0] wq [$];
  logic [7:0]  rq [$];
  logic        reg_wr_00, mode11_00, twd_00, rsp_valid_00;
  logic [7:0]  rsp_data_00, reg_wr_addr_00, reg_wr_data_00, reg_rd_addr_00, reg_rd_data_00;
  logic [15:0] wz [$];
  logic [7:0]  rz [$];
  int          bad_count = 0;
  int          checks_done = 0;

  always #2.5 clk = ~clk;

  spi_link_if i_spi_link_if ();
  spi_sensor_port i_spi_sensor_port
  (
    .clk(clk), .reset(reset), .link(i_spi_link_if.dev), .three_wire_enable(three_wire_enable),
    .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .mode11(mode11),
    .two_wire_disable(two_wire_disable)
  );
  spi_master_end i_spi_master_end
  (
    .clk(clk), .reset(reset), .link(i_spi_link_if.host), .three_wire_enable(three_wire_enable),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_hold(cmd_hold),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy(busy)
  );
  spi_link_if i_spi_link_if_00 ();
  spi_sensor_port i_spi_sensor_port_00
  (
    .clk(clk), .reset(reset), .link(i_spi_link_if_00.dev), .three_wire_enable(three_wire_enable),
    .reg_wr(reg_wr_00), .reg_wr_addr(reg_wr_addr_00), .reg_wr_data(reg_wr_data_00),
    .reg_rd(), .reg_rd_addr(reg_rd_addr_00), .reg_rd_data(reg_rd_data_00), .mode11(mode11_00),
    .two_wire_disable(twd_00)
  );
  // Mode 00 twin of the master; same timing, so it takes the same commands in lockstep
  spi_master_end #(.MODE11(1'h0)) i_spi_master_end_00
  (
    .clk(clk), .reset(reset), .link(i_spi_link_if_00.host), .three_wire_enable(three_wire_enable),
    .cmd_valid(cmd_valid), .cmd_ready(), .cmd_write(cmd_write), .cmd_hold(cmd_hold),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len), .rsp_valid(rsp_valid_00),
    .rsp_data(rsp_data_00), .busy()
  );
  spi_link_props i_spi_link_props
  (
    .clk(clk), .reset(reset), .three_wire_enable(three_wire_enable),
    .sck(i_spi_link_if.sck), .csb_n(i_spi_link_if.csb_n), .sdi_m_o(i_spi_link_if.sdi_m_o),
    .sdi_m_oe_n(i_spi_link_if.sdi_m_oe_n), .sdi_s_o(i_spi_link_if.sdi_s_o),
    .sdi_s_oe_n(i_spi_link_if.sdi_s_oe_n), .sdo_o(i_spi_link_if.sdo_o),
    .sdo_oe_n(i_spi_link_if.sdo_oe_n), .mode11(mode11), .two_wire_disable(two_wire_disable)
  );

  // Register file behind the port; untouched locations read as address xor 3C
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3C;
  assign reg_rd_data = mem[reg_rd_addr];
  assign reg_rd_data_00 = mem[reg_rd_addr_00];

  always @(posedge clk)
  begin
    if (reg_wr === 1'h1)
    begin
      mem[reg_wr_addr] <= reg_wr_data;
      wq.push_back({reg_wr_addr, reg_wr_data});
    end
    if (rsp_valid === 1'h1)
      rq.push_back(rsp_data);
    if (reg_wr_00 === 1'h1)
      wz.push_back({reg_wr_addr_00, reg_wr_data_00});
    if (rsp_valid_00 === 1'h1)
      rz.push_back(rsp_data_00);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until the edge that sees ready, then lets one edge pass
  task automatic send(input logic wr, input logic hold, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] n);
    int t;
    t = 0;
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_hold <= hold;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_len <= n;
    do
      @(posedge clk);
    while (cmd_ready !== 1'h1 && ++t < 4000);
    if (t >= 4000)
      bad_count++;
    cmd_valid <= 1'h0;
    @(posedge clk);
  endtask

  task automatic settle();
    int t;
    t = 0;
    repeat (8) @(posedge clk);
    while ((busy !== 1'h0 || cmd_ready !== 1'h1) && t < 4000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 4000)
      bad_count++;
    repeat (8) @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    chk(16'(two_wire_disable), 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      three_wire_enable <= m[0];
      for (int i = 0; i < 3; i++)
        send(1'h1, i < 2, WA[m][i], WD[m][i], 8'h00);
      settle();
      for (int i = 0; i < 3; i++)
      begin
        chk(wq.size() ? wq.pop_front() : 16'hXXXX, {1'h1, WA[m][i][6:0], WD[m][i]});
        chk(wz.size() ? wz.pop_front() : 16'hXXXX, {1'h1, WA[m][i][6:0], WD[m][i]});
      end
      chk(16'(wq.size()), 16'h0000);
      chk(16'(wz.size()), 16'h0000);
      send(1'h0, 1'h0, RA[m], 8'h00, 8'h03);
      settle();
      for (int i = 0; i < 3; i++)
      begin
        chk({8'h00, rq.size() ? rq.pop_front() : 8'hXX}, {8'h00, ER[m][i]});
        chk({8'h00, rz.size() ? rz.pop_front() : 8'hXX}, {8'h00, ER[m][i]});
      end
      chk(16'(rq.size()), 16'h0000);
      chk(16'(rz.size()), 16'h0000);
      chk(16'(mode11), 16'h0001);
      chk(16'(mode11_00), 16'h0000);
      chk(16'(two_wire_disable), 16'h0001);
      chk(16'(twd_00), 16'h0001);
    end
    end_of_test();
  end
endmodule
